// ==== rtl/ncr_nav_core.sv ====
/*
 Navigation report block: control-port register access, movement
 accumulation, movement and click status, click gap setting.
 Assumes the host keeps words well spaced (slow control link) so that
 each reply byte is ready before the next word's first falling edge.
*/
`timescale 1ns/1ps
`include "ncr_defs.svh"

// How it works
// - gap code selects 5..31 slice limit
// - click only when transitions closer than limit
// - motion count above threshold raises interrupt
// - threshold compared shifted left one bit
// - one read returns all three report bytes
// - report cleared after each read
// - overflow flags set on counter overflow
// - sign flags follow movement direction
// - click sets status b7 and flags b1
// - status read clears status click bit, not flags b1
// - magnitudes are unsigned 8-bit, reset zero
// - 8-bit words, MSB first, full duplex
// - only host starts transfers
// - deselected: output released, input ignored
// - clock idles high, sample rising edge
// - bit counter cleared only by reset pin
// - writes to read-only registers ignored
// - b7 set marks command, clear marks data
// - command holds read flag and address
// - status read clears pending bits, releases interrupt

module ncr_nav_core (
   // system clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // control link
   input wire logic ctrl_sck_in,
   input wire logic control_port_select_n_in,
   input wire logic ctrl_mosi_in,
   output logic ctrl_miso_out,
   output logic ctrl_miso_oe_out,
   // sensing events
   input wire logic slice_tick_in,
   input wire logic transition_test_flag_in,
   input wire logic x_step_in,
   input wire logic x_step_neg_in,
   input wire logic y_step_in,
   input wire logic y_step_neg_in,
   // host interrupt
   output logic host_irq_out
);
   import ncr_pkg::*;

   // reset pin to link domain: constant clear, released by a flop
   logic link_rst_n_q;

   // crossings from the link domain
   logic [7:0] rx_word;
   logic rx_tgl;
   logic rx_tgl_s1_q;
   logic rx_tgl_s2_q;
   logic rx_tgl_s3_q;
   logic sel_n_s1_q;
   logic sel_n_s2_q;

   // protocol
   ncr_state_t state_q;
   ncr_state_t state_d;
   logic [3:0] addr_q;
   logic [1:0] nav_idx_q;
   logic [7:0] tx_byte_q;

   // registers
   logic [6:0] thresh_q;
   logic [6:0] clickctrl_q;
   logic st_click_q;
   logic st_mov_q;

   // report accumulators and snapshot
   logic [7:0] x_mag_q;
   logic [7:0] y_mag_q;
   logic x_ovf_q;
   logic y_ovf_q;
   logic x_neg_q;
   logic y_neg_q;
   logic nav_click_q;
   logic [7:0] snap_x_q;
   logic [7:0] snap_y_q;
   logic mov_cmp_q;
   logic click_evt;

   ncr_spi_link u_link (
      .sck_in(ctrl_sck_in),
      .rst_n_in(link_rst_n_q),
      .sel_n_in(control_port_select_n_in),
      .mosi_in(ctrl_mosi_in),
      .miso_out(ctrl_miso_out),
      .tx_byte_in(tx_byte_q),
      .rx_word_out(rx_word),
      .rx_tgl_out(rx_tgl)
   );

   ncr_click_det u_click (
      .clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .gap_code_in(clickctrl_q[2:0]),
      .slice_tick_in(slice_tick_in),
      .transition_in(transition_test_flag_in),
      .click_out(click_evt)
   );

   // word decode; rx_word is stable for a whole word after the toggle
   wire word_stb = rx_tgl_s2_q ^ rx_tgl_s3_q;
   wire is_cmd = rx_word[`NCR_CMD_TYPE_BIT];
   wire is_read = rx_word[`NCR_CMD_READ_BIT];
   wire [3:0] cmd_addr = rx_word[`NCR_CMD_ADDR_HI:`NCR_CMD_ADDR_LO];
   wire cmd_stb = word_stb && is_cmd;
   wire data_stb = word_stb && !is_cmd;
   wire rd_status = cmd_stb && is_read && (cmd_addr == `NCR_ADDR_STATUS);
   wire rd_nav = cmd_stb && is_read && (cmd_addr == `NCR_ADDR_NAV);
   wire wr_stb = data_stb && (state_q == NCR_ST_WR);
   wire wr_thresh = wr_stb && (addr_q == `NCR_ADDR_THRESH);
   wire wr_click = wr_stb && (addr_q == `NCR_ADDR_CLICKCTRL);
   wire nav_next = data_stb && (state_q == NCR_ST_RD) && (addr_q == `NCR_ADDR_NAV);

   // report bytes as presented
   wire [7:0] flags_now = {y_ovf_q, x_ovf_q, y_neg_q, x_neg_q, 2'b00, nav_click_q, 1'b0};
   wire [7:0] status_now = {st_click_q, 6'h00, st_mov_q};

   // motion above threshold, threshold taken as twice its value
   wire [7:0] thr2 = {thresh_q, 1'b0};
   wire mov_cmp = (x_mag_q > thr2) || (y_mag_q > thr2);
   wire mov_evt = mov_cmp && !mov_cmp_q;

   // accumulator next values: clear on report read, a same-cycle step still counts
   wire x_full = (x_mag_q == `NCR_MAG_MAX);
   wire y_full = (y_mag_q == `NCR_MAG_MAX);
   wire [7:0] x_base = rd_nav ? 8'h00 : x_mag_q;
   wire [7:0] y_base = rd_nav ? 8'h00 : y_mag_q;
   wire x_sat = x_full && !rd_nav;
   wire y_sat = y_full && !rd_nav;

   // reply byte for a command
   wire [7:0] cmd_reply = rd_status ? status_now :
                          rd_nav ? flags_now :
                          (cmd_addr == `NCR_ADDR_THRESH) ? {1'b0, thresh_q} :
                          (cmd_addr == `NCR_ADDR_CLICKCTRL) ? {1'b0, clickctrl_q} :
                          8'h00;
   wire [7:0] nav_reply = (nav_idx_q == 2'h0) ? snap_x_q :
                          (nav_idx_q == 2'h1) ? snap_y_q : 8'h00;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         NCR_ST_CMD:
            if (cmd_stb)
               state_d = is_read ? NCR_ST_RD : NCR_ST_WR;
         NCR_ST_WR:
            if (cmd_stb)
               state_d = is_read ? NCR_ST_RD : NCR_ST_WR;
            else if (data_stb)
               state_d = NCR_ST_CMD;
         NCR_ST_RD:
            if (cmd_stb)
               state_d = is_read ? NCR_ST_RD : NCR_ST_WR;
            else if (data_stb && !(nav_next && nav_idx_q != 2'h2))
               state_d = NCR_ST_CMD;
         default:
            state_d = NCR_ST_CMD;
      endcase
   end

   // reset and synchronisers
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         link_rst_n_q <= 1'b0;
         rx_tgl_s1_q <= 1'b0;
         rx_tgl_s2_q <= 1'b0;
         rx_tgl_s3_q <= 1'b0;
         sel_n_s1_q <= 1'b1;
         sel_n_s2_q <= 1'b1;
         ctrl_miso_oe_out <= 1'b0;
      end
      else
      begin
         link_rst_n_q <= 1'b1;
         rx_tgl_s1_q <= rx_tgl;
         rx_tgl_s2_q <= rx_tgl_s1_q;
         rx_tgl_s3_q <= rx_tgl_s2_q;
         sel_n_s1_q <= control_port_select_n_in;
         sel_n_s2_q <= sel_n_s1_q;
         ctrl_miso_oe_out <= !sel_n_s2_q;
      end
   end

   // protocol state and reply byte
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         state_q <= NCR_ST_CMD;
         addr_q <= 4'h0;
         nav_idx_q <= 2'h0;
         tx_byte_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         if (cmd_stb)
         begin
            addr_q <= cmd_addr;
            nav_idx_q <= 2'h0;
            tx_byte_q <= is_read ? cmd_reply : 8'h00;
         end
         else if (nav_next)
         begin
            nav_idx_q <= nav_idx_q + 2'h1;
            tx_byte_q <= nav_reply;
         end
         else if (data_stb)
            tx_byte_q <= 8'h00;
      end
   end

   // writable registers; other addresses take no write
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         thresh_q <= `NCR_THRESH_RST;
         clickctrl_q <= `NCR_CLICKCTRL_RST;
      end
      else
      begin
         if (wr_thresh)
            thresh_q <= rx_word[6:0];
         if (wr_click)
            clickctrl_q <= rx_word[6:0];
      end
   end

   // status bits: a new event in the read cycle stays pending
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         st_click_q <= 1'b0;
         st_mov_q <= 1'b0;
         mov_cmp_q <= 1'b0;
         host_irq_out <= 1'b0;
      end
      else
      begin
         mov_cmp_q <= mov_cmp;
         st_click_q <= click_evt || (st_click_q && !rd_status);
         st_mov_q <= mov_evt || (st_mov_q && !rd_status);
         host_irq_out <= click_evt || mov_evt ||
                         ((st_click_q || st_mov_q) && !rd_status);
      end
   end

   // report accumulators, snapshot taken by the report read
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         x_mag_q <= 8'h00;
         y_mag_q <= 8'h00;
         x_ovf_q <= 1'b0;
         y_ovf_q <= 1'b0;
         x_neg_q <= 1'b0;
         y_neg_q <= 1'b0;
         nav_click_q <= 1'b0;
         snap_x_q <= 8'h00;
         snap_y_q <= 8'h00;
      end
      else
      begin
         if (rd_nav)
         begin
            snap_x_q <= x_mag_q;
            snap_y_q <= y_mag_q;
         end
         // magnitude saturates at 255 and the overflow flag records it
         x_mag_q <= (x_step_in && !x_sat) ? x_base + 8'h01 : x_base;
         y_mag_q <= (y_step_in && !y_sat) ? y_base + 8'h01 : y_base;
         x_ovf_q <= (x_step_in && x_sat) || (x_ovf_q && !rd_nav);
         y_ovf_q <= (y_step_in && y_sat) || (y_ovf_q && !rd_nav);
         x_neg_q <= x_step_in ? x_step_neg_in : (x_neg_q && !rd_nav);
         y_neg_q <= y_step_in ? y_step_neg_in : (y_neg_q && !rd_nav);
         // status read leaves this bit alone
         nav_click_q <= click_evt || (nav_click_q && !rd_nav);
      end
   end

endmodule : ncr_nav_core

// ==== common/ncr_defs.svh ====
/*
 Constants of the navigation report block: register addresses, field
 positions, reset values and click gap limits.
 Assumes it is included by bare name, once per compilation unit.
*/
`ifndef NCR_DEFS_SVH
`define NCR_DEFS_SVH

// register addresses (4-bit, command word b5..b2)
`define NCR_ADDR_STATUS 4'h0
`define NCR_ADDR_CLICKCTRL 4'h5
`define NCR_ADDR_THRESH 4'h6
`define NCR_ADDR_NAV 4'h8

// command word fields
`define NCR_CMD_TYPE_BIT 7
`define NCR_CMD_READ_BIT 6
`define NCR_CMD_ADDR_HI 5
`define NCR_CMD_ADDR_LO 2

// status register bits
`define NCR_STAT_CLICK_BIT 7
`define NCR_STAT_MOV_BIT 0

// navigation flags register bits
`define NCR_FLAG_Y_OVERFLOW_FLAG_BIT 7
`define NCR_FLAG_X_OVERFLOW_FLAG_BIT 6
`define NCR_FLAG_YNEG_BIT 5
`define NCR_FLAG_XNEG_BIT 4
`define NCR_FLAG_CLICK_BIT 1

// reset values and magnitude limit
`define NCR_THRESH_RST 7'h00
`define NCR_CLICKCTRL_RST 7'h2D
`define NCR_MAG_MAX 8'hFF

// click gap limits in slices, codes 000..111
`define NCR_GAP_0 5'h05
`define NCR_GAP_1 5'h07
`define NCR_GAP_2 5'h0A
`define NCR_GAP_3 5'h0C
`define NCR_GAP_4 5'h10
`define NCR_GAP_5 5'h14
`define NCR_GAP_6 5'h19
`define NCR_GAP_7 5'h1F

`endif

// ==== common/ncr_pkg.sv ====
/*
 Types and shared decoding of the navigation report block.
 Assumes ncr_defs.svh is on the include path.
*/
`include "ncr_defs.svh"

package ncr_pkg;

   typedef enum logic [2:0] {
      NCR_ST_CMD = 3'b001,
      NCR_ST_WR = 3'b010,
      NCR_ST_RD = 3'b100
   } ncr_state_t;

   typedef logic [4:0] ncr_gap_t;

   function automatic ncr_gap_t ncr_gap_limit(input logic [2:0] code);
      ncr_gap_t lim;
      lim = `NCR_GAP_0;
      unique case (code)
         3'h0: lim = `NCR_GAP_0;
         3'h1: lim = `NCR_GAP_1;
         3'h2: lim = `NCR_GAP_2;
         3'h3: lim = `NCR_GAP_3;
         3'h4: lim = `NCR_GAP_4;
         3'h5: lim = `NCR_GAP_5;
         3'h6: lim = `NCR_GAP_6;
         3'h7: lim = `NCR_GAP_7;
      endcase
      return lim;
   endfunction : ncr_gap_limit

endpackage : ncr_pkg

// ==== rtl/ncr_spi_link.sv ====
/*
 Link-side shifter of the control port, clocked by the host's serial clock.
 Assumes clock idles high, sample on rising, drive on falling edge; the
 async clear comes from a flop of the system domain.
*/
`timescale 1ns/1ps

module ncr_spi_link (
   // link clock and clear
   input wire logic sck_in,
   input wire logic rst_n_in,
   // pins
   input wire logic sel_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   // system side, tx_byte_in held stable between words
   input wire logic [7:0] tx_byte_in,
   output logic [7:0] rx_word_out,
   output logic rx_tgl_out
);
   import ncr_pkg::*;

   logic [2:0] bit_cnt_q;
   logic [6:0] rx_sh_q;
   logic [6:0] tx_sh_q;
   wire word_end = (bit_cnt_q == 3'h7);

   // counter clears only on the reset pin; a short access stays misaligned
   always_ff @(posedge sck_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bit_cnt_q <= 3'h0;
         rx_sh_q <= 7'h00;
         rx_word_out <= 8'h00;
         rx_tgl_out <= 1'b0;
      end
      else if (!sel_n_in)
      begin
         rx_sh_q <= {rx_sh_q[5:0], mosi_in};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (word_end)
         begin
            rx_word_out <= {rx_sh_q, mosi_in};
            rx_tgl_out <= ~rx_tgl_out;
         end
      end
   end

   always_ff @(negedge sck_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         miso_out <= 1'b0;
         tx_sh_q <= 7'h00;
      end
      else if (!sel_n_in)
      begin
         if (bit_cnt_q == 3'h0)
         begin
            miso_out <= tx_byte_in[7];
            tx_sh_q <= tx_byte_in[6:0];
         end
         else
         begin
            miso_out <= tx_sh_q[6];
            tx_sh_q <= {tx_sh_q[5:0], 1'b0};
         end
      end
   end

endmodule : ncr_spi_link

// ==== rtl/ncr_click_det.sv ====
/*
 Click detector: two finger transitions closer than the gap limit.
 Assumes slice and transition pulses are one cycle wide on sys_clk.
*/
`timescale 1ns/1ps

module ncr_click_det (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // control
   input wire logic [2:0] gap_code_in,
   // events
   input wire logic slice_tick_in,
   input wire logic transition_in,
   output logic click_out
);
   import ncr_pkg::*;

   logic armed_q;
   logic [4:0] gap_q;
   wire ncr_gap_t limit = ncr_gap_limit(gap_code_in);
   wire is_click = transition_in && armed_q && (gap_q < limit);

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         armed_q <= 1'b0;
         gap_q <= 5'h00;
         click_out <= 1'b0;
      end
      else
      begin
         click_out <= is_click;
         if (transition_in)
         begin
            // a click consumes both edges; otherwise this edge opens a window
            armed_q <= !is_click;
            gap_q <= 5'h00;
         end
         else if (slice_tick_in && armed_q)
         begin
            gap_q <= gap_q + 5'h01;
            if (gap_q + 5'h01 >= limit)
               armed_q <= 1'b0;
         end
      end
   end

endmodule : ncr_click_det

// ==== dv/ncr_nav_core_chk.sv ====
/*
 Checker for ncr_nav_core: select to miso enable timing, quiet reset exit,
 interrupt cause and release windows.
 Assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/1ps

module ncr_nav_core_chk (
   // system clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // control link
   input wire logic ctrl_sck_in,
   input wire logic control_port_select_n_in,
   input wire logic ctrl_mosi_in,
   input wire logic ctrl_miso_out,
   input wire logic ctrl_miso_oe_out,
   // sensing events
   input wire logic slice_tick_in,
   input wire logic transition_test_flag_in,
   input wire logic x_step_in,
   input wire logic x_step_neg_in,
   input wire logic y_step_in,
   input wire logic y_step_neg_in,
   // host interrupt
   input wire logic host_irq_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);
   logic [3:0] ev_age_q;
   logic [4:0] sel_age_q;
   wire ev_any = x_step_in | y_step_in | transition_test_flag_in;
   // ages saturate so a long idle never wraps back into a window
   wire [3:0] ev_age_d = ev_any ? 4'h0 : (ev_age_q == 4'hF) ? ev_age_q : ev_age_q + 4'h1;
   wire [4:0] sel_age_d = !control_port_select_n_in ? 5'h00 :
      (sel_age_q == 5'h1F) ? sel_age_q : sel_age_q + 5'h01;
   always_ff @(posedge sys_clk_in)
   begin
      ev_age_q <= resetn_in ? ev_age_d : 4'hF;
      sel_age_q <= resetn_in ? sel_age_d : 5'h1F;
   end
   sequence s_sel_idle;
      control_port_select_n_in [*3];
   endsequence
   sequence s_sel_busy;
      !control_port_select_n_in [*4];
   endsequence
   a_quiet_exit: assert property ($rose(resetn_in) |-> !host_irq_out && !ctrl_miso_oe_out)
      else $error("irq or miso enable set at reset exit");
   a_oe_release: assert property (s_sel_idle |=> !ctrl_miso_oe_out)
      else $error("miso enabled while deselected");
   a_oe_drive: assert property (s_sel_busy |-> ctrl_miso_oe_out)
      else $error("miso not enabled while selected");
   a_oe_rise_cause: assert property ($rose(ctrl_miso_oe_out) |-> !$past(control_port_select_n_in, 3))
      else $error("miso enable rose without select");
   a_oe_fall_cause: assert property ($fell(ctrl_miso_oe_out) |-> $past(control_port_select_n_in, 3))
      else $error("miso enable fell while selected");
   a_irq_cause: assert property ($rose(host_irq_out) |-> ev_age_q <= 4'h6)
      else $error("irq rose with no recent event");
   a_irq_release: assert property ($fell(host_irq_out) |-> sel_age_q <= 5'h0C)
      else $error("irq dropped with no host access");
   a_irq_steady: assert property (ev_age_q > 4'h6 && sel_age_q > 5'h0C |-> $stable(host_irq_out))
      else $error("irq moved while link and events idle");
endmodule : ncr_nav_core_chk

bind ncr_nav_core ncr_nav_core_chk u_chk (
   .sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in),
   .ctrl_sck_in(ctrl_sck_in),
   .control_port_select_n_in(control_port_select_n_in),
   .ctrl_mosi_in(ctrl_mosi_in),
   .ctrl_miso_out(ctrl_miso_out),
   .ctrl_miso_oe_out(ctrl_miso_oe_out),
   .slice_tick_in(slice_tick_in),
   .transition_test_flag_in(transition_test_flag_in),
   .x_step_in(x_step_in),
   .x_step_neg_in(x_step_neg_in),
   .y_step_in(y_step_in),
   .y_step_neg_in(y_step_neg_in),
   .host_irq_out(host_irq_out)
);

// ==== dv/ncr_host_model.sv ====
/*
 Host master of the control link: 6 ns serial clock, select framing,
 full duplex 8-bit words.
 Assumes tb calls sel and word; miso pin is Z while released.
*/
`timescale 1ns/1ps

module ncr_host_model (
   // link pins
   output logic sck_out,
   output logic sel_n_out,
   output logic mosi_out,
   input wire logic miso_in
);
   initial
   begin
      sck_out = 1'b1;
      sel_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   task automatic sel(input logic v);
      // non-blocking: a change on a system edge is seen after that edge
      sel_n_out <= v;
      // miso enable lags select by three system cycles
      #100;
   endtask : sel
   task automatic word(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sck_out = 1'b0;
         mosi_out = tx[i];
         #3;
         sck_out = 1'b1;
         rx[i] = miso_in;
         #3;
      end
      mosi_out = ~mosi_out;
      // reply byte needs up to three system cycles (75 ns) after the word
      #250;
   endtask : word
   // clock pulses with no data, for a cut access
   task automatic pulses(input int n);
      repeat (n)
      begin
         sck_out = 1'b0;
         #3;
         sck_out = 1'b1;
         #3;
      end
      #250;
   endtask : pulses
endmodule : ncr_host_model

// ==== dv/tb.sv ====
/*
 Top bench: register access, motion, overflow and click sequences on
 ncr_nav_core through the host model.
 Assumes the checker binds itself to the core.
*/
`timescale 1ns/1ps

module tb;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic tick = 1'b0;
   logic trn = 1'b0;
   logic xs = 1'b0;
   logic ys = 1'b0;
   logic ng = 1'b0;
   logic sck;
   logic sel_n;
   logic mosi;
   logic miso;
   logic oe;
   logic irq;
   wire miso_pin = oe ? miso : 1'bz;
   int fails = 0;
   int check_count = 0;
   logic [7:0] got [3];
   int gap [8] = '{5, 7, 10, 12, 16, 20, 25, 31};
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   ncr_nav_core DUT (
      .sys_clk_in(sys_clk),
      .resetn_in(resetn),
      .ctrl_sck_in(sck),
      .control_port_select_n_in(sel_n),
      .ctrl_mosi_in(mosi),
      .ctrl_miso_out(miso),
      .ctrl_miso_oe_out(oe),
      .slice_tick_in(tick),
      .transition_test_flag_in(trn),
      .x_step_in(xs),
      .x_step_neg_in(ng),
      .y_step_in(ys),
      .y_step_neg_in(ng),
      .host_irq_out(irq)
   );
   ncr_host_model u_host (
      .sck_out(sck),
      .sel_n_out(sel_n),
      .mosi_out(mosi),
      .miso_in(miso_pin)
   );
   task automatic test_done;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [6:0] d);
      logic [7:0] r;
      u_host.sel(1'b0);
      u_host.word({2'b10, a, 2'b00}, r);
      u_host.word({1'b0, d}, r);
      u_host.sel(1'b1);
   endtask : wr
   task automatic rd(input logic [3:0] a, input int n);
      logic [7:0] r;
      u_host.sel(1'b0);
      u_host.word({2'b11, a, 2'b00}, r);
      for (int i = 0; i < n; i++)
      begin
         u_host.word(8'h00, r);
         got[i] = r;
      end
      u_host.sel(1'b1);
   endtask : rd
   task automatic nav(input logic [7:0] f, input logic [7:0] x, input logic [7:0] y);
      rd(4'h8, 3);
      chk("nav flags", got[0], f);
      chk("abs x", got[1], x);
      chk("abs y", got[2], y);
   endtask : nav
   // m is {transition, slice, y step, x step}
   task automatic ev(input logic [3:0] m, input logic neg, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         {trn, tick, ys, xs} <= m;
         ng <= neg;
         @(posedge sys_clk);
         {trn, tick, ys, xs} <= 4'h0;
      end
   endtask : ev
   task automatic wait_irq(input logic v);
      int k;
      k = 0;
      while (irq !== v && k < 40)
      begin
         @(negedge sys_clk);
         k++;
      end
      chk("irq", {7'h00, irq}, {7'h00, v});
      if (irq !== v)
         test_done();
   endtask : wait_irq
   initial
   begin
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(4'h6, 1);
      chk("thresh rst", got[0], 8'h00);
      rd(4'h5, 1);
      chk("gap rst", got[0], 8'h2D);
      nav(8'h00, 8'h00, 8'h00);
      wr(4'h6, 7'h02);
      rd(4'h6, 1);
      chk("thresh", got[0], 8'h02);
      ev(4'h1, 1'b0, 4);
      repeat (10) @(negedge sys_clk);
      chk("irq quiet", {7'h00, irq}, 8'h00);
      ev(4'h1, 1'b0, 1);
      wait_irq(1'b1);
      ev(4'h2, 1'b1, 2);
      rd(4'h0, 1);
      chk("status mov", got[0], 8'h01);
      wait_irq(1'b0);
      nav(8'h20, 8'h05, 8'h02);
      nav(8'h00, 8'h00, 8'h00);
      wr(4'h8, 7'h7F);
      wr(4'h0, 7'h7F);
      rd(4'h0, 1);
      chk("status ro", got[0], 8'h00);
      nav(8'h00, 8'h00, 8'h00);
      wr(4'h6, 7'h7F);
      ev(4'h1, 1'b1, 256);
      rd(4'h0, 1);
      chk("status ovf", got[0], 8'h01);
      nav(8'h50, 8'hFF, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(4'h5, {4'h5, c[2:0]});
         ev(4'h8, 1'b0, 1);
         ev(4'h4, 1'b0, gap[c]);
         ev(4'h8, 1'b0, 1);
         rd(4'h0, 1);
         chk("no click", got[0], 8'h00);
         ev(4'h4, 1'b0, gap[c] - 1);
         ev(4'h8, 1'b0, 1);
         rd(4'h0, 1);
         chk("click stat", got[0], 8'h80);
         nav(8'h02, 8'h00, 8'h00);
      end
      // cut access of four pulses, then only the reset pin realigns the link
      u_host.sel(1'b0);
      u_host.pulses(4);
      u_host.sel(1'b1);
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(4'h5, 1);
      chk("resync gap", got[0], 8'h2D);
      rd(4'h6, 1);
      chk("resync thresh", got[0], 8'h00);
      test_done();
   end
endmodule : tb
